/* File: rtl/uart_rx_defs.svh */
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH
// Oversampling: samples per bit and majority-vote sample numbers
`define OVS_NORMAL      5'd16
`define OVS_DOUBLE      5'd8
`define VOTE_FIRST_N    5'd8
`define VOTE_FIRST_D    5'd4
// Receive buffer depth (entries)
`define RXBUF_DEPTH     2
// Reset values
`define RST_DATA        8'h00
`define RST_CNT         5'h00
`define RST_BITS        4'h0
`endif

/* File: rtl/uart_rx_pkg.sv */
package uart_rx_pkg;
  // One received frame with its error flags
  typedef struct packed {
    logic       frame_error_flag;
    logic       overrun_flag;
    logic       parity_error_flag;
    logic [7:0] data;
  } rx_entry_s;

  // Frame format configuration
  typedef struct packed {
    logic       double_speed_select;
    logic       parity_enable_bit;
    logic       parity_type_bit;
    logic       stop_bit_count_select;
    logic [1:0] char_size;  // 0:5 1:6 2:7 3:8 data bits
  } rx_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10
  } rx_state_e;
endpackage : uart_rx_pkg

/* File: rtl/uart_rx_core.sv */
// Functional notes
// - Receive-complete flag is one exactly while the buffer holds unread data.
// - Clearing receiver enable flushes the buffer so the flag reads zero.
// - Interrupt request holds while flag, its enable and global enable are set.
// - Error flags stored per entry; data read advances buffer read position.
// - Software writes cannot alter stored error flags.
// - Error flags never generate an interrupt.
// - Frame error is one when first stop bit sampled low.
// - Only first stop bit is checked; extra stop bits ignored.
// - Overrun when buffer full, shifter holds frame, and new start detected.
// - Overrun cleared when a frame transfers from shifter into buffer.
// - Parity error reads zero when parity checking is disabled.
// - Parity checked only when enabled; type bit selects odd or even.
// - Parity error stored with data, valid until that data is read.
// - Disabling receiver is immediate; frame in progress abandoned, pin released.
// - Sample at 16x baud normally, 8x baud in double speed.
// - Falling edge on idle line starts detection; first low sample is one.
// - Start validated by vote on samples 8-10 or 4-6; noise rejected.
// - Valid start aligns bit timing; repeated for every frame.
// - Each following bit resolved by majority of its three centre samples.
`timescale 1ns/1ps
`include "uart_rx_defs.svh"

module uart_rx_core (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // Serial line and oversample tick from the baud generator
  input  wire logic                 i_rxd,
  input  wire logic                 i_sample_tick,
  // Configuration
  input  wire logic                 i_receiver_enable,
  input  wire logic                 i_rx_complete_int_enable,
  input  wire logic                 i_global_int_enable,
  input  wire uart_rx_pkg::rx_cfg_s i_cfg,
  // Software read of the data location (one-cycle pulse)
  input  wire logic                 i_data_read,
  // Status and data
  output logic                      o_rx_complete_flag,
  output logic                      o_rx_complete_irq,
  output uart_rx_pkg::rx_entry_s    o_head,
  output logic                      o_pin_override
);

  // Majority of three samples
  function automatic logic vote3(input logic a, input logic b, input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction : vote3

  ////////////////////////////////////////////////////////////////////////
  // Input synchronizer: first stage feeds only the second
  logic sync1_r;
  logic sync2_r;
  logic rxd_prev_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      rxd_prev_r <= 1'b1;
    end else begin
      sync1_r    <= i_rxd;
      sync2_r    <= sync1_r;
      rxd_prev_r <= i_sample_tick ? sync2_r : rxd_prev_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling geometry selected by speed mode
  wire logic [4:0] spb      = i_cfg.double_speed_select ? `OVS_DOUBLE : `OVS_NORMAL;
  wire logic [4:0] v_first  = i_cfg.double_speed_select ? `VOTE_FIRST_D : `VOTE_FIRST_N;
  wire logic [3:0] n_bits   = 4'd5 + {2'b00, i_cfg.char_size};
  wire logic [3:0] last_bit = n_bits + {3'b000, i_cfg.parity_enable_bit}; // stop bit index

  uart_rx_pkg::rx_state_e state_r;
  logic [4:0]             cnt_r;      // sample number within current bit, from 1
  logic [3:0]             bit_r;      // 0..n-1 data, then parity, then stop
  logic [2:0]             votes_r;
  logic [7:0]             shift_r;
  logic                   par_r;
  logic                   pend_r;     // complete frame waiting in shifter
  uart_rx_pkg::rx_entry_s pend_q_r;
  logic                   dor_r;      // overrun to attach to next stored frame

  wire logic fall     = i_sample_tick & rxd_prev_r & ~sync2_r;
  wire logic at_vote3 = i_sample_tick & (cnt_r == v_first + 5'd2);
  wire logic bit_end  = i_sample_tick & (cnt_r == spb);
  wire logic voted    = vote3(votes_r[2], votes_r[1], sync2_r);
  wire logic par_calc = ^(shift_r) ^ i_cfg.parity_type_bit;

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer: two entries with per-entry error flags
  uart_rx_pkg::rx_entry_s buf_r [`RXBUF_DEPTH];
  logic                   rd_ptr_r;
  logic [1:0]             count_r;
  wire logic full      = (count_r == 2'd2);
  wire logic do_read   = i_data_read & (count_r != 2'd0);
  wire logic do_write  = pend_r & (~full | do_read);
  wire logic wr_ptr    = rd_ptr_r ^ count_r[0];

  // Frame-level sequencer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r  <= uart_rx_pkg::ST_IDLE;
      cnt_r    <= `RST_CNT;
      bit_r    <= `RST_BITS;
      votes_r  <= 3'h0;
      shift_r  <= `RST_DATA;
      par_r    <= 1'b0;
      pend_r   <= 1'b0;
      pend_q_r <= '0;
      dor_r    <= 1'b0;
    end else if (!i_receiver_enable) begin
      state_r <= uart_rx_pkg::ST_IDLE;  // Immediate abandon
      pend_r  <= 1'b0;
      dor_r   <= 1'b0;
    end else begin
      if (do_write) begin
        pend_r <= 1'b0;
        dor_r  <= 1'b0;
      end
      case (state_r)
        uart_rx_pkg::ST_IDLE: begin
          if (fall) begin
            state_r <= uart_rx_pkg::ST_START;
            cnt_r   <= 5'd2;                   // Next sample is number two
            if (pend_r & full & ~do_read)
              dor_r <= 1'b1;
          end
        end
        uart_rx_pkg::ST_START: begin
          if (i_sample_tick) begin
            cnt_r      <= cnt_r + 5'd1;
            votes_r[2] <= votes_r[1];
            votes_r[1] <= sync2_r;
            if (at_vote3) begin
              if (voted)
                state_r <= uart_rx_pkg::ST_IDLE;  // Noise spike
            end
            if (bit_end) begin
              state_r <= uart_rx_pkg::ST_DATA;  // Realigned to start
              cnt_r   <= 5'd1;
              bit_r   <= `RST_BITS;
              shift_r <= `RST_DATA;
            end
          end
        end
        uart_rx_pkg::ST_DATA: begin
          if (i_sample_tick) begin
            cnt_r      <= bit_end ? 5'd1 : cnt_r + 5'd1;
            votes_r[2] <= votes_r[1];
            votes_r[1] <= sync2_r;
            if (at_vote3) begin
              bit_r <= bit_r + 4'd1;
              if (bit_r < n_bits)
                shift_r[bit_r[2:0]] <= voted;
              else if (bit_r != last_bit)
                par_r <= voted;
              else begin
                // First stop bit ends frame; others are left to idle
                state_r                     <= uart_rx_pkg::ST_IDLE;
                pend_r                      <= 1'b1;
                pend_q_r.data               <= shift_r;
                pend_q_r.frame_error_flag   <= ~voted;
                pend_q_r.parity_error_flag  <= i_cfg.parity_enable_bit & (par_calc != par_r);
                pend_q_r.overrun_flag       <= 1'b0;
              end
            end
          end
        end
        default: state_r <= uart_rx_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer bookkeeping; there is no software write path to stored flags
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr_r <= 1'b0;
      count_r  <= 2'd0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else if (!i_receiver_enable) begin
      rd_ptr_r <= 1'b0;  // Flush
      count_r  <= 2'd0;
    end else begin
      if (do_write)
        buf_r[wr_ptr] <= '{pend_q_r.frame_error_flag, dor_r, pend_q_r.parity_error_flag,
                           pend_q_r.data};
      if (do_read)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'b0, do_write} - {1'b0, do_read};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire logic [1:0] count_nxt = !i_receiver_enable ? 2'd0 : count_r + {1'b0, do_write} - {1'b0, do_read};
  // A frame written while the last stored entry is read (or into an empty buffer) is the new head at once
  wire logic       head_new  = do_write & (count_r == {1'b0, do_read});
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_complete_flag <= 1'b0;
      o_rx_complete_irq  <= 1'b0;
      o_pin_override     <= 1'b0;
      o_head             <= '0;
    end else begin
      o_rx_complete_flag <= (count_nxt != 2'd0);
      // Only the complete flag drives the request
      o_rx_complete_irq  <= (count_nxt != 2'd0) & i_rx_complete_int_enable & i_global_int_enable;
      o_pin_override     <= i_receiver_enable;
      o_head             <= (count_nxt == 2'd0) ? '0 :
                            head_new ? '{pend_q_r.frame_error_flag, dor_r,
                                                  pend_q_r.parity_error_flag, pend_q_r.data} :
                            buf_r[rd_ptr_r ^ do_read];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_tracks;
    @(posedge i_clk) disable iff (!i_arst_n) o_rx_complete_flag == (count_r != 2'd0);
  endproperty
  a_flag_tracks: assert property (p_flag_tracks) else $error("complete flag wrong");
  property p_flush;
    @(posedge i_clk) disable iff (!i_arst_n) !i_receiver_enable |=> !o_rx_complete_flag;
  endproperty
  a_flush: assert property (p_flush) else $error("flush failed");
  property p_irq;
    @(posedge i_clk) disable iff (!i_arst_n) o_rx_complete_irq ==
      (o_rx_complete_flag & $past(i_rx_complete_int_enable) & $past(i_global_int_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_abandon;
    @(posedge i_clk) disable iff (!i_arst_n) !i_receiver_enable |=> state_r == uart_rx_pkg::ST_IDLE;
  endproperty
  a_abandon: assert property (p_abandon) else $error("frame not abandoned");
  property p_pe_off;
    @(posedge i_clk) disable iff (!i_arst_n) (pend_r & !i_cfg.parity_enable_bit & !$past(pend_r))
      |-> !pend_q_r.parity_error_flag;
  endproperty
  a_pe_off: assert property (p_pe_off) else $error("parity flag while disabled");
  property p_sync;
    @(posedge i_clk) disable iff (!i_arst_n) sync2_r == $past(i_rxd, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchronizer depth");
  property p_count_max;
    @(posedge i_clk) disable iff (!i_arst_n) count_r <= 2'd2;
  endproperty
  a_count_max: assert property (p_count_max) else $error("buffer over depth");
  property p_read_adv;
    @(posedge i_clk) disable iff (!i_arst_n) (i_receiver_enable & do_read & !do_write) |=>
      count_r == $past(count_r) - 2'd1;
  endproperty
  a_read_adv: assert property (p_read_adv) else $error("read did not advance");

  // Head is always the oldest stored entry, also when a write meets a read of the last entry
  property p_head_oldest;
    @(posedge i_clk) disable iff (!i_arst_n) o_rx_complete_flag |-> o_head == buf_r[rd_ptr_r];
  endproperty
  a_head_oldest: assert property (p_head_oldest) else $error("head is not the oldest entry");
  property p_irq_needs_flag;
    @(posedge i_clk) disable iff (!i_arst_n) o_rx_complete_irq |-> o_rx_complete_flag;
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("request without complete flag");

  // Frame steps: vote on the start bit, end of the start bit, vote on the first stop bit
  sequence s_start_vote;
    i_receiver_enable && state_r == uart_rx_pkg::ST_START && at_vote3;
  endsequence
  sequence s_start_end;
    i_receiver_enable && state_r == uart_rx_pkg::ST_START && bit_end;
  endsequence
  sequence s_stop_vote;
    i_receiver_enable && state_r == uart_rx_pkg::ST_DATA && at_vote3 && bit_r == last_bit;
  endsequence
  // A start seen while both entries and the shifter are taken loses a character
  sequence s_lost_start;
    i_receiver_enable && state_r == uart_rx_pkg::ST_IDLE && fall && pend_r && full && !do_read;
  endsequence

  property p_noise_drop;
    @(posedge i_clk) disable iff (!i_arst_n) s_start_vote ##0 voted |=> state_r == uart_rx_pkg::ST_IDLE;
  endproperty
  a_noise_drop: assert property (p_noise_drop) else $error("noise start kept");
  property p_start_keep;
    @(posedge i_clk) disable iff (!i_arst_n) s_start_vote ##0 !voted |=> state_r == uart_rx_pkg::ST_START;
  endproperty
  a_start_keep: assert property (p_start_keep) else $error("valid start dropped");
  property p_start_align;
    @(posedge i_clk) disable iff (!i_arst_n) s_start_end |=>
      state_r == uart_rx_pkg::ST_DATA && cnt_r == 5'd1 && bit_r == `RST_BITS;
  endproperty
  a_start_align: assert property (p_start_align) else $error("bit timing not aligned");
  // Frame error of a finished frame is the inverse of its first stop-bit vote
  property p_stop_frame;
    @(posedge i_clk) disable iff (!i_arst_n) s_stop_vote |=>
      pend_r && state_r == uart_rx_pkg::ST_IDLE && pend_q_r.frame_error_flag == !$past(voted);
  endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("stop bit handling wrong");
  property p_lost_mark;
    @(posedge i_clk) disable iff (!i_arst_n) s_lost_start |=> dor_r;
  endproperty
  a_lost_mark: assert property (p_lost_mark) else $error("overrun not marked");
  property p_dor_clear;
    @(posedge i_clk) disable iff (!i_arst_n) (i_receiver_enable && do_write) |=> !dor_r;
  endproperty
  a_dor_clear: assert property (p_dor_clear) else $error("overrun not cleared on store");
  // Sample numbers stay inside one bit of the mode; only holds while the mode is steady during a frame
  property p_cnt_range;
    @(posedge i_clk) disable iff (!i_arst_n) state_r != uart_rx_pkg::ST_IDLE |-> cnt_r >= 5'd1 && cnt_r <= spb;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("sample number out of range");

endmodule : uart_rx_core

/* File: test/uart_tx_line_model.sv */
`timescale 1ns/1ps
// Remote transmitter; every bit lasts one full set of oversample ticks
module uart_tx_line_model (
  // Clock and oversample tick
  input  wire logic i_clk,
  input  wire logic i_tick,
  // Serial line, idle high
  output wire logic o_line
);
  // Single variable behind the line, idle high from the start
  logic line_r = 1'b1;
  assign o_line = line_r;
  // Changes land just after an edge, then hold for n ticks
  task automatic hold_bit(input logic v, input int n);
    line_r <= v;
    repeat (n) @(posedge i_clk iff i_tick);
  endtask : hold_bit
  // Start, data LSB first, optional parity, stop, one idle bit
  task automatic send(input logic [7:0] d, input int nb, input logic pe, pv, sv, input int n);
    @(posedge i_clk);
    hold_bit(1'b0, n);
    for (int i = 0; i < nb; i++) hold_bit(d[i], n);
    if (pe) hold_bit(pv, n);
    hold_bit(sv, n);
    hold_bit(1'b1, n);  // Gives a clean falling edge for the next frame
  endtask : send
endmodule : uart_tx_line_model

/* File: test/uart_receiver_status_and_start_sync_tb.sv */
`timescale 1ns/1ps
module uart_receiver_status_and_start_sync_tb;
  logic                   clk, arst_n, en, ie, gie, line, flag, irq, pin, reads_on;
  logic                   tick = 1'b0;
  logic                   rd = 1'b0;
  logic                   seen = 1'b0;
  uart_rx_pkg::rx_cfg_s   cfg;
  uart_rx_pkg::rx_entry_s head;
  uart_rx_pkg::rx_entry_s exp_q[$];
  int                     bad_count = 0;
  int                     total_checks = 0;
  int                     gap = 0;
  logic [31:0]            rng = 32'h25;

  uart_rx_core u_uart_rx_core (.i_clk(clk), .i_arst_n(arst_n), .i_rxd(line), .i_sample_tick(tick),
    .i_receiver_enable(en), .i_rx_complete_int_enable(ie), .i_global_int_enable(gie), .i_cfg(cfg),
    .i_data_read(rd), .o_rx_complete_flag(flag), .o_rx_complete_irq(irq), .o_head(head),
    .o_pin_override(pin));
  uart_tx_line_model u_uart_tx_line_model (.i_clk(clk), .i_tick(tick), .o_line(line));

  ////////////////////////////////////////////////////////////////
  // Clock; tick every second cycle keeps frames short
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick <= ~tick;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] e, s);
    total_checks++;
    if (e !== s) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Note the expected entry, then let the remote side send it
  task automatic frame(input logic [7:0] d, input logic bad_par, sv, ov, keep);
    logic [7:0]             m;
    logic                   pv;
    uart_rx_pkg::rx_entry_s e;
    m = d & (8'hff >> (2'd3 - cfg.char_size));
    pv = (^m) ^ cfg.parity_type_bit ^ bad_par;
    e = '{frame_error_flag: ~sv, overrun_flag: ov, parity_error_flag: cfg.parity_enable_bit & bad_par, data: m};
    if (keep) exp_q.push_back(e);
    u_uart_tx_line_model.send(d, cfg.char_size + 5, cfg.parity_enable_bit, pv, sv, cfg.double_speed_select ? 8 : 16);
  endtask : frame

  ////////////////////////////////////////////////////////////////
  // Reader: status is compared first, then the data read pulses
  // Status is only ever read here, never written, so its error positions see no ones
  always @(posedge clk) begin
    rd <= 1'b0;
    seen <= (flag === 1'b1);
    if (gap > 0) gap <= gap - 1;
    else if (reads_on && seen && flag === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected frame", 0, 1);
      else check("head", exp_q.pop_front(), head);
      check("irq", ie & gie, irq);
      rd <= 1'b1;
      gap <= 4;
    end
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0;
    en = 1'b1;
    ie = 1'b0;
    gie = 1'b0;
    cfg = '0;
    reads_on = 1'b1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("pin", 1, pin);
    // Sizes, speeds, parity kinds, bad stop bits
    for (int k = 0; k < 12; k++) begin
      rng = xs(rng);
      cfg <= {k[2], k[3] | k[0], k[1], rng[0], k[1:0]};
      ie <= rng[1];
      gie <= rng[2];
      @(posedge clk);
      frame(rng[15:8], rng[3], (k % 5) != 4, 1'b0, 1'b1);
    end
    repeat (60) @(posedge clk);
    check("flag empty", 0, flag);
    // Short low spike is rejected as noise
    cfg <= 6'h03;
    u_uart_tx_line_model.hold_bit(1'b0, 3);
    // Idle long enough that a wrongly kept start would finish a frame and show up
    u_uart_tx_line_model.hold_bit(1'b1, 170);
    check("flag noise", 0, flag);
    // Overrun: two stored, one in shifter, third lost at fourth start
    reads_on <= 1'b0;
    frame(8'h11, 1'b0, 1'b1, 1'b0, 1'b1);
    frame(8'h22, 1'b0, 1'b1, 1'b0, 1'b1);
    // Third waits in the shifter and is lost at the fourth start; the fourth carries the overrun
    frame(8'h33, 1'b0, 1'b1, 1'b0, 1'b0);
    frame(8'h44, 1'b0, 1'b1, 1'b1, 1'b1);
    reads_on <= 1'b1;
    frame(8'h55, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (60) @(posedge clk);
    // Disable flushes the buffer and releases the pin
    reads_on <= 1'b0;
    frame(8'ha5, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    check("flag full", 1, flag);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    check("flag flushed", 0, flag);
    check("pin off", 0, pin);
    en <= 1'b1;
    // Frame abandoned when disabled part way through
    fork
      frame(8'h5a, 1'b0, 1'b1, 1'b0, 1'b0);
      begin
        repeat (150) @(posedge clk);
        en <= 1'b0;
      end
    join
    en <= 1'b1;
    reads_on <= 1'b1;
    repeat (40) @(posedge clk);
    check("flag abandoned", 0, flag);
    check("queue", 0, exp_q.size());
    give_verdict();
  end
endmodule : uart_receiver_status_and_start_sync_tb
